// >>> logic/txcfg_defs.vh
// Constants for the transmit enable / clock phase / amplitude pin logic
`ifndef TXCFG_DEFS_VH
`define TXCFG_DEFS_VH

// Deglitch time in ns and clock period in ns
`define TXCFG_DEGLITCH_NS 625
`define TXCFG_CLK_NS 10
// Deglitch time rounds down to whole cycles, 62 at these values
`define TXCFG_DEGLITCH_CYC (`TXCFG_DEGLITCH_NS / `TXCFG_CLK_NS)
`define TXCFG_CNT_W 7

// Device states
`define TXCFG_ST_RESET 2'h0
`define TXCFG_ST_CONFIG 2'h1
`define TXCFG_ST_NORMAL 2'h2
`define TXCFG_ST_STANDBY 2'h3

// Reset values
`define TXCFG_ENABLE_RST 1'h1
`define TXCFG_AMP_RST 1'h0
`define TXCFG_PHASE_RST 1'h0

`endif

// >>> logic/txcfg_pins.v
// Sampling, deglitch and latching of the transmit enable/phase and amplitude pins
//
// Overview of operation
// - Slave role: pin high queues received frame
// - Enable low: discard shifted data, queue nothing
// - Enable captured at chip select, held frame
// - Master role: phase captured during config latch
// - Phase 0 first edge, phase 1 second
// - Pull-up on in config and normal
// - Open pin reads high, transmitter enabled
// - Amplitude pin 0 low, 1 high
// - Slave: amplitude at select, applied then, or at transmit done if busy
// - Master: amplitude filtered, applied at frame start
// - Standby: amplitude captured during wakeup
// - Reset: amplitude captured during first power-up
// - Up/reset counters deglitch both inputs
`timescale 1ns/1ps
`include "txcfg_defs.vh"

module txcfg_pins (
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // Device pins
  input wire txEnablePhasePin,
  input wire txAmplitudeSelect,
  input wire chipSelectN,
  input wire sck,
  // Device state and role
  input wire [1:0] devState,
  input wire roleSelect,
  input wire wakeupActive,
  input wire powerupActive,
  // Frame events from SPI and isolated transmitter
  input wire frameShifted,
  input wire isoTxStart,
  input wire isoTxDone,
  // Outputs
  output reg txQueuePush,
  output reg txEnable,
  output reg clockPhase,
  output reg sampleStrobe,
  output reg highLineAmplitude,
  output reg pullUpEnable
);

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  reg [1:0] enSync_q;
  reg [1:0] ampSync_q;
  reg [1:0] csSync_q;
  reg [1:0] sckSync_q;
  reg csPrev_q;
  reg sckPrev_q;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      enSync_q <= 2'h3;
      ampSync_q <= 2'h0;
      csSync_q <= 2'h3;
      sckSync_q <= 2'h0;
      csPrev_q <= 1'h1;
      sckPrev_q <= 1'h0;
    end else begin
      enSync_q <= {enSync_q[0], txEnablePhasePin};
      ampSync_q <= {ampSync_q[0], txAmplitudeSelect};
      csSync_q <= {csSync_q[0], chipSelectN};
      sckSync_q <= {sckSync_q[0], sck};
      csPrev_q <= csSync_q[1];
      sckPrev_q <= sckSync_q[1];
    end
  end

  wire csFall = csPrev_q & ~csSync_q[1];
  wire sckEdge = sckPrev_q ^ sckSync_q[1];

  // ----------------------------------------------------------------
  // Deglitch filters
  // ----------------------------------------------------------------
  // Counter restarts on any change; filtered level follows only once stable
  function [`TXCFG_CNT_W-1:0] glitchCount;
    input [`TXCFG_CNT_W-1:0] cnt;
    input changed;
    begin
      if (changed) begin
        glitchCount = {`TXCFG_CNT_W{1'b0}};
      end else if (cnt < `TXCFG_DEGLITCH_CYC) begin
        glitchCount = cnt + 1'b1;
      end else begin
        glitchCount = cnt;
      end
    end
  endfunction

  reg enLast_q;
  reg ampLast_q;
  reg [`TXCFG_CNT_W-1:0] enCnt_q;
  reg [`TXCFG_CNT_W-1:0] ampCnt_q;
  reg enFilt_q;
  reg ampFilt_q;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      enLast_q <= 1'h1;
      ampLast_q <= 1'h0;
      enCnt_q <= {`TXCFG_CNT_W{1'b0}};
      ampCnt_q <= {`TXCFG_CNT_W{1'b0}};
      enFilt_q <= `TXCFG_ENABLE_RST;
      ampFilt_q <= `TXCFG_AMP_RST;
    end else begin
      enLast_q <= enSync_q[1];
      ampLast_q <= ampSync_q[1];
      enCnt_q <= glitchCount(enCnt_q, enSync_q[1] ^ enLast_q);
      ampCnt_q <= glitchCount(ampCnt_q, ampSync_q[1] ^ ampLast_q);
      if (enCnt_q >= `TXCFG_DEGLITCH_CYC - 1) begin
        enFilt_q <= enLast_q;
      end
      if (ampCnt_q >= `TXCFG_DEGLITCH_CYC - 1) begin
        ampFilt_q <= ampLast_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Enable / phase latching
  // ----------------------------------------------------------------
  wire isNormal = (devState == `TXCFG_ST_NORMAL);
  wire isConfig = (devState == `TXCFG_ST_CONFIG);
  reg [1:0] edgeCnt_q;
  reg ampPend_q;
  reg ampBusy_q;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      txEnable <= `TXCFG_ENABLE_RST;
      clockPhase <= `TXCFG_PHASE_RST;
      txQueuePush <= 1'h0;
      sampleStrobe <= 1'h0;
      edgeCnt_q <= 2'h0;
      pullUpEnable <= 1'h0;
    end else begin
      // Pull-up keeps an open pin high, so transmit stays enabled
      pullUpEnable <= isConfig | isNormal;
      if (isConfig && roleSelect) begin
        clockPhase <= enFilt_q;
      end
      // Captured once per frame so a late change never chops a frame
      if (csFall && !roleSelect && isNormal) begin
        txEnable <= enFilt_q;
      end
      // Queue only when enabled; otherwise data is dropped
      txQueuePush <= frameShifted & ~roleSelect & txEnable & isNormal;
      if (csFall) begin
        edgeCnt_q <= 2'h0;
      end else if (sckEdge && !csSync_q[1] && edgeCnt_q != 2'h3) begin
        edgeCnt_q <= edgeCnt_q + 2'h1;
      end
      sampleStrobe <= roleSelect & sckEdge & ~csSync_q[1] &
                      (edgeCnt_q == (clockPhase ? 2'h1 : 2'h0));
    end
  end

  // ----------------------------------------------------------------
  // Amplitude latching
  // ----------------------------------------------------------------
  // No pipelining: a later capture overwrites an earlier pending one
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      highLineAmplitude <= `TXCFG_AMP_RST;
      ampPend_q <= `TXCFG_AMP_RST;
      ampBusy_q <= 1'h0;
    end else begin
      if (isoTxStart) begin
        ampBusy_q <= 1'h1;
      end else if (isoTxDone) begin
        ampBusy_q <= 1'h0;
      end
      if (powerupActive || wakeupActive) begin
        // Raw synchronised level: filter not yet settled during power-up
        highLineAmplitude <= ampSync_q[1];
        ampPend_q <= ampSync_q[1];
      end else if (isNormal && roleSelect) begin
        if (isoTxStart) begin
          highLineAmplitude <= ampFilt_q;
        end
      end else if (isNormal) begin
        if (csFall) begin
          ampPend_q <= ampFilt_q;
        end
        if (!ampBusy_q || isoTxDone) begin
          highLineAmplitude <= csFall ? ampFilt_q : ampPend_q;
        end
      end
    end
  end

endmodule

// >>> sim/txcfg_pins_monitor.sv
// Port assertions for the enable/phase/amplitude pin block
`timescale 1ns/1ps
module txcfg_pins_monitor (
  input wire clk, reset_n, txEnablePhasePin, txAmplitudeSelect, chipSelectN, sck,
  input wire [1:0] devState,
  input wire roleSelect, wakeupActive, powerupActive, frameShifted, isoTxStart, isoTxDone,
  input wire txQueuePush, txEnable, clockPhase, sampleStrobe, highLineAmplitude, pullUpEnable
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  push_on_frame_a: assert property (
    frameShifted && txEnable && !roleSelect && devState == 2'h2 |=> txQueuePush)
    else $error("frame not pushed");
  push_cause_a: assert property (
    txQueuePush |-> $past(frameShifted && txEnable && !roleSelect))
    else $error("push without enabled frame");
  enable_held_a: assert property (
    chipSelectN [*6] |=> $stable(txEnable)) else $error("enable moved outside select");
  phase_frozen_a: assert property (
    $past(devState) != 2'h1 && $past(devState, 2) != 2'h1 |-> $stable(clockPhase))
    else $error("phase moved outside config");
  pullup_on_a: assert property (
    devState == 2'h1 || devState == 2'h2 |-> ##[0:2] pullUpEnable) else $error("pull-up off");
  pullup_off_a: assert property (
    devState == 2'h3 |-> ##[0:2] !pullUpEnable) else $error("pull-up on in standby");
  amp_master_a: assert property (
    roleSelect && devState == 2'h2 && $past(devState) == 2'h2 && $changed(highLineAmplitude)
    |-> $past(isoTxStart) || $past(isoTxStart, 2)) else $error("amplitude moved mid frame");
  amp_wake_a: assert property (
    (wakeupActive && txAmplitudeSelect) [*8] |=> highLineAmplitude)
    else $error("wakeup amplitude not taken");
endmodule
bind txcfg_pins txcfg_pins_monitor mon_u (.*);

// >>> sim/txcfg_host.sv
// Host model: one SPI frame per go pulse, link clock idle low between frames
`timescale 1ns/1ps
module txcfg_host (
  input wire clk,
  input wire go,
  output reg chipSelectN,
  output reg sck,
  output reg frameShifted
);
  initial begin
    chipSelectN = 1'h1;
    sck = 1'h0;
    frameShifted = 1'h0;
  end
  always @(posedge go) begin
    #800 chipSelectN = 1'h0;
    repeat (16) #62.5 sck = ~sck;
    #300 chipSelectN = 1'h1;
    @(posedge clk) frameShifted <= 1'h1;
    @(posedge clk) frameShifted <= 1'h0;
  end
endmodule

// >>> sim/tb_top.sv
// Self-checking bench for the enable/phase/amplitude pin block
`timescale 1ns/1ps
module tb_top;
  reg clk = 1'h0, reset_n = 1'h0, txEnablePhasePin = 1'h1, txAmplitudeSelect = 1'h0;
  reg roleSelect = 1'h0, wakeupActive = 1'h0, powerupActive = 1'h0, go = 1'h0;
  reg isoTxStart = 1'h0, isoTxDone = 1'h0;
  reg [1:0] devState = 2'h2;
  reg [31:0] seed = 32'h88a0;
  wire chipSelectN, sck, frameShifted, txQueuePush, txEnable, clockPhase, sampleStrobe;
  wire highLineAmplitude, pullUpEnable;
  int fails = 0, n_tests = 0, k, strobeCount = 0;
  bit expq[$];
  txcfg_host host_u (.*);
  txcfg_pins dut_u (.*);
  function automatic [31:0] xs(input [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  task automatic check(input logic seen, input logic exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %0t got %b want %b", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Bounded wait so a stuck frame ends the run
  task automatic frame(input bit exp);
    expq.push_back(exp);
    go <= 1'h1;
    @(posedge clk) go <= 1'h0;
    for (k = 0; k < 400 && frameShifted !== 1'h1; k++) @(posedge clk);
    if (k == 400) begin
      fails++;
      end_sim;
    end
    ticks(4);
  endtask
  always @(posedge clk) if (frameShifted === 1'h1) begin
    @(negedge clk);
    check(txQueuePush, expq.pop_front());
  end
  always @(posedge clk) if (sampleStrobe === 1'h1) strobeCount++;
  initial begin
    forever #5 clk = ~clk;
  end
  initial begin
    ticks(8);
    check(txEnable, 1'h1);
    reset_n <= 1'h1;
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      txEnablePhasePin <= i[0];
      txAmplitudeSelect <= seed[0];
      frame(i[0]);
      check(txEnable, i[0]);
      check(highLineAmplitude, seed[0]);
    end
    $display("slave frames done");
    roleSelect <= 1'h1;
    devState <= 2'h1;
    txEnablePhasePin <= 1'h1;
    ticks(80);
    devState <= 2'h2;
    txEnablePhasePin <= 1'h0;
    txAmplitudeSelect <= ~seed[0];
    strobeCount = 0;
    frame(1'h0);
    check(clockPhase, 1'h1);
    check(logic'(strobeCount == 1), 1'h1);
    ticks(80);
    check(highLineAmplitude, seed[0]);
    isoTxStart <= 1'h1;
    ticks(1);
    isoTxStart <= 1'h0;
    ticks(3);
    check(highLineAmplitude, ~seed[0]);
    $display("master done");
    devState <= 2'h3;
    txAmplitudeSelect <= 1'h1;
    ticks(4);
    check(pullUpEnable, 1'h0);
    wakeupActive <= 1'h1;
    ticks(12);
    check(highLineAmplitude, 1'h1);
    wakeupActive <= 1'h0;
    devState <= 2'h2;
    ticks(4);
    check(pullUpEnable, 1'h1);
    $display("standby done");
    devState <= 2'h0;
    txAmplitudeSelect <= 1'h0;
    powerupActive <= 1'h1;
    ticks(8);
    check(highLineAmplitude, 1'h0);
    powerupActive <= 1'h0;
    $display("power-up done");
    end_sim;
  end
endmodule
